// File: cpm_pkg.sv
// cpm_pkg: shared types and constants for the core power mode controller.
// assumes one clock domain and a synchronous active-high reset.
package cpm_pkg;

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CPM_ON,
        CPM_FUNCTIONAL_RETENTION,
        CPM_FULL_RETENTION,
        CPM_OFF,
        CPM_EMU_OFF,
        CPM_DEBUG_RECOVERY,
        CPM_WARM_RST
    } cpm_mode_t;

    localparam int        CPM_TMR_W     = 8;
    localparam logic [7:0] CPM_TMR_RST  = 8'h10;
    localparam logic [3:0] CPM_CLEAN_CYC = 4'h4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 req;
        cpm_mode_t            mode;
    } cpm_req_t;

    typedef struct packed {
        logic                 ret_en;      // functional retention enable
        logic [CPM_TMR_W-1:0] ret_len;     // retention timer length
        logic                 rst_req_bit; // reset management request bit
    } cpm_cfg_t;

    typedef struct packed {
        logic in_wait;       // core in interrupt/event wait state
        logic wake_evt;      // architectural wait wakeup
        logic tmp_clk;       // snoop, maintenance, debug or ctrl access
        logic vec_idle;
        logic vec_pending;   // vector instruction waiting
        logic peer_vec_req;  // sharing core wants functional retention
        logic peer_off;      // other core of the complex is off
        logic wfi_exec;      // wait-for-interrupt executing
        logic bridge_warm;   // warm reset from cpu bridge
        logic dbg_acc;       // debug or utility bus access
    } cpm_core_t;

    typedef enum logic [1:0] {
        CPM_PH_IDLE,
        CPM_PH_CLEAN,
        CPM_PH_ACK
    } cpm_phase_t;

    typedef struct packed {
        cpm_mode_t            mode;
        cpm_mode_t            target;
        cpm_phase_t           phase;
        logic [3:0]           cnt;
        logic [CPM_TMR_W-1:0] tmr;
        logic                 accept;
        logic                 vec_off;
        logic                 vec_req;
        logic                 clean_l1;
        logic                 clean_l2;
        logic                 coherent;
        logic                 inval;
        logic                 warm_rst;
        logic                 pwr_on;
        logic                 clk_en;
        logic                 dbg_err;
        logic                 dbg_live;
        logic                 warm_req;
        logic                 from_off;
    } cpm_state_t;

endpackage

// File: cpm_core_power.sv
// cpm_core_power: per-core power mode controller.
// assumes the policy controller holds a request until it is accepted.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) only seven defined power modes exist
// (R2) full retention only from wait state
// (R3) vector off when idle and timer expired
// (R4) retention enable and timer length programmable
// (R5) pending vector instruction wakes vector unit
// (R6) shared vector retention needs all cores
// (R7) full retention needs timer, wait, no clock
// (R8) wakeup or temporary clock leaves full retention
// (R9) off cleans caches, leaves coherency, powers down
// (R10) single core off keeps l2 uncleaned
// (R11) access to off core gets error
// (R12) emulated off keeps power and debug
// (R13) emulated off: no gating, warm reset only
// (R14) on completion caches coherent and accessible
// (R15) off to on invalidates caches
// (R16) debug recovery keeps caches and error state
// (R17) debug recovery from any mode, warm reset
// (R18) debug recovery accepted without draining
// (R19) warm reset keeps debug, trace, monitor, errors
// (R20) bridge warm reset signal applies warm reset
// (R21) reset request bit plus interrupt wait requests reset
// (R22) controller avoids debug recovery in normal use
// (R23) request held until accept after entry actions
module cpm_core_power (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire cpm_pkg::cpm_req_t  i_req,
    input  wire cpm_pkg::cpm_cfg_t  i_cfg,
    input  wire cpm_pkg::cpm_core_t i_core,
    output var  logic             o_accept,
    output var  cpm_pkg::cpm_mode_t o_mode,
    output var  logic             o_vec_off,
    output var  logic             o_vec_ret_req,
    output var  logic             o_clean_l1,
    output var  logic             o_clean_l2,
    output var  logic             o_coherent,
    output var  logic             o_inval,
    output var  logic             o_warm_rst,
    output var  logic             o_pwr_on,
    output var  logic             o_clk_en,
    output var  logic             o_dbg_err,
    output var  logic             o_dbg_live,
    output var  logic             o_warm_req
);
    import cpm_pkg::*;

    cpm_state_t s_reg;
    cpm_state_t s_next;
    logic       legal;
    logic       tmr_done;

    always_comb begin
        legal    = (i_req.mode <= CPM_WARM_RST); // R1
        tmr_done = (s_reg.tmr == '0);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next          = s_reg;
        s_next.accept   = 1'b0;
        s_next.inval    = 1'b0;
        s_next.warm_req = 1'b0;
        s_next.dbg_err  = 1'b0;

        // retention timer restarts on any activity
        if (!i_core.in_wait || i_core.tmp_clk || i_core.wake_evt
            || !i_core.vec_idle) begin
            s_next.tmr = i_cfg.ret_len; // R4
        end else if (!tmr_done) begin
            s_next.tmr = s_reg.tmr - 1'b1;
        end

        // functional retention of the vector unit
        s_next.vec_req = i_cfg.ret_en && i_core.vec_idle && tmr_done
                         && !i_core.vec_pending; // R3 R4
        if (i_core.vec_pending || !i_cfg.ret_en) begin
            s_next.vec_off = 1'b0; // R5
        end else if (s_reg.vec_req && i_core.peer_vec_req
                     && s_reg.mode == CPM_FUNCTIONAL_RETENTION) begin
            s_next.vec_off = 1'b1; // R6
        end

        // leave full retention on wakeup or temporary clock
        if (s_reg.mode == CPM_FULL_RETENTION
            && (i_core.wake_evt || i_core.tmp_clk)) begin
            s_next.mode   = CPM_ON; // R8
            s_next.clk_en = 1'b1;
        end

        s_next.dbg_err = i_core.dbg_acc && s_reg.mode == CPM_OFF; // R11
        s_next.warm_req = i_cfg.rst_req_bit && i_core.wfi_exec; // R21

        // bridge warm reset: trace and monitor state live outside this block;
        // dbg_live and dbg_err are kept here but the warm reset never touches them
        s_next.warm_rst = i_core.bridge_warm
                          || s_reg.mode == CPM_DEBUG_RECOVERY
                          || s_reg.mode == CPM_EMU_OFF; // R19 R20

        case (s_reg.phase)
            CPM_PH_IDLE: begin
                if (i_req.req && legal && !s_reg.accept) begin // R23
                    s_next.target = i_req.mode;
                    s_next.cnt    = '0;
                    case (i_req.mode)
                        CPM_DEBUG_RECOVERY: begin
                            // no drain: taken the same cycle
                            s_next.mode     = CPM_DEBUG_RECOVERY; // R17 R18
                            s_next.warm_rst = 1'b1;
                            s_next.pwr_on   = 1'b1; // R16
                            s_next.clk_en   = 1'b1;
                            s_next.from_off = 1'b0;
                            s_next.phase    = CPM_PH_ACK;
                        end
                        CPM_OFF, CPM_EMU_OFF: begin
                            s_next.clean_l1 = 1'b1; // R9 R13
                            s_next.clean_l2 = !i_core.peer_off ? 1'b0
                                                               : 1'b1; // R10
                            s_next.phase    = CPM_PH_CLEAN;
                        end
                        CPM_FULL_RETENTION: begin
                            if (i_core.in_wait && tmr_done
                                && !i_core.tmp_clk) begin // R2 R7
                                s_next.mode   = CPM_FULL_RETENTION;
                                s_next.clk_en = 1'b0;
                                s_next.phase  = CPM_PH_ACK;
                            end
                        end
                        CPM_ON: begin
                            s_next.inval    = s_reg.from_off; // R15
                            s_next.from_off = 1'b0;
                            s_next.pwr_on   = 1'b1;
                            s_next.clk_en   = 1'b1;
                            s_next.warm_rst = i_core.bridge_warm;
                            s_next.coherent = 1'b1; // R14
                            s_next.mode     = CPM_ON;
                            s_next.phase    = CPM_PH_ACK;
                        end
                        CPM_FUNCTIONAL_RETENTION: begin
                            s_next.mode  = CPM_FUNCTIONAL_RETENTION;
                            s_next.phase = CPM_PH_ACK;
                        end
                        CPM_WARM_RST: begin
                            s_next.mode     = CPM_WARM_RST;
                            s_next.warm_rst = 1'b1;
                            s_next.phase    = CPM_PH_ACK;
                        end
                        default: begin
                            s_next.phase = CPM_PH_IDLE;
                        end
                    endcase
                end
            end
            CPM_PH_CLEAN: begin
                // fixed clean time stands in for cache flush handshake
                if (s_reg.cnt == CPM_CLEAN_CYC) begin
                    s_next.clean_l1 = 1'b0;
                    s_next.clean_l2 = 1'b0;
                    s_next.coherent = 1'b0; // R9
                    s_next.mode     = s_reg.target;
                    if (s_reg.target == CPM_OFF) begin
                        s_next.pwr_on   = 1'b0; // R9
                        s_next.clk_en   = 1'b0;
                        s_next.from_off = 1'b1;
                        s_next.dbg_live = 1'b0;
                    end else begin
                        s_next.pwr_on   = 1'b1; // R12 R13
                        s_next.clk_en   = 1'b1;
                        s_next.warm_rst = 1'b1;
                        s_next.dbg_live = 1'b1;
                    end
                    s_next.phase = CPM_PH_ACK;
                end else begin
                    s_next.cnt = s_reg.cnt + 4'h1;
                end
            end
            CPM_PH_ACK: begin
                s_next.accept = 1'b1; // R23
                if (s_reg.target != CPM_EMU_OFF) begin
                    s_next.dbg_live = s_reg.target != CPM_OFF;
                end
                s_next.phase  = CPM_PH_IDLE;
            end
            default: begin
                s_next.phase = CPM_PH_IDLE;
            end
        endcase

        if (i_srst) begin
            s_next          = '0;
            s_next.mode     = CPM_ON;
            s_next.target   = CPM_ON;
            s_next.phase    = CPM_PH_IDLE;
            s_next.tmr      = CPM_TMR_RST;
            s_next.coherent = 1'b1;
            s_next.pwr_on   = 1'b1;
            s_next.clk_en   = 1'b1;
            s_next.dbg_live = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        o_accept      = s_reg.accept;
        o_mode        = s_reg.mode;
        o_vec_off     = s_reg.vec_off;
        o_vec_ret_req = s_reg.vec_req;
        o_clean_l1    = s_reg.clean_l1;
        o_clean_l2    = s_reg.clean_l2;
        o_coherent    = s_reg.coherent;
        o_inval       = s_reg.inval;
        o_warm_rst    = s_reg.warm_rst;
        o_pwr_on      = s_reg.pwr_on;
        o_clk_en      = s_reg.clk_en;
        o_dbg_err     = s_reg.dbg_err;
        o_dbg_live    = s_reg.dbg_live;
        o_warm_req    = s_reg.warm_req;
    end

endmodule

`default_nettype wire

// File: cpm_core_power_properties.sv
// cpm_core_power_properties: port timing checks on the mode controller.
// assumes one clock and the design's synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cpm_core_power_properties (
    input wire logic               i_clk,
    input wire logic               i_srst,
    input wire cpm_pkg::cpm_req_t  i_req,
    input wire cpm_pkg::cpm_cfg_t  i_cfg,
    input wire cpm_pkg::cpm_core_t i_core,
    input wire logic               o_accept,
    input wire cpm_pkg::cpm_mode_t o_mode,
    input wire logic               o_clean_l1,
    input wire logic               o_clean_l2,
    input wire logic               o_coherent,
    input wire logic               o_inval,
    input wire logic               o_warm_rst,
    input wire logic               o_pwr_on,
    input wire logic               o_clk_en,
    input wire logic               o_dbg_err,
    input wire logic               o_dbg_live,
    input wire logic               o_warm_req
);
    import cpm_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_full_in;
        o_mode == CPM_FULL_RETENTION && $past(o_mode) != CPM_FULL_RETENTION
            |-> $past(i_core.in_wait && !i_core.tmp_clk);
    endproperty
    a_full_in: assert property (p_full_in) else $error("bad entry");
    property p_full_out;
        o_mode == CPM_FULL_RETENTION && (i_core.wake_evt || i_core.tmp_clk)
            |=> o_mode == CPM_ON;
    endproperty
    a_full_out: assert property (p_full_out) else $error("no wake");
    property p_off;
        o_mode == CPM_OFF |-> !o_pwr_on && !o_clk_en && !o_coherent;
    endproperty
    a_off: assert property (p_off) else $error("off powered");
    property p_l2;
        $rose(o_clean_l1) |-> o_clean_l2 == $past(i_core.peer_off);
    endproperty
    a_l2: assert property (p_l2) else $error("l2 clean");
    property p_err;
        o_mode == CPM_OFF && i_core.dbg_acc |=> o_dbg_err;
    endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_emu;
        o_mode == CPM_EMU_OFF && $past(o_mode) == CPM_EMU_OFF
            |-> o_pwr_on && o_clk_en && o_warm_rst && o_dbg_live;
    endproperty
    a_emu: assert property (p_emu) else $error("emu off");
    property p_rec;
        i_req.req && i_req.mode == CPM_DEBUG_RECOVERY && !o_accept
            |-> ##[1:3] o_accept;
    endproperty
    a_rec: assert property (p_rec) else $error("slow recovery");
    property p_wreq;
        i_core.wfi_exec && i_cfg.rst_req_bit |=> o_warm_req;
    endproperty
    a_wreq: assert property (p_wreq) else $error("no warm req");
    c_off: cover property (o_mode == CPM_OFF && o_accept);
    c_wake: cover property (o_mode == CPM_FULL_RETENTION ##1 o_mode == CPM_ON);
    c_inval: cover property (o_inval);
endmodule
bind cpm_core_power cpm_core_power_properties chk (.i_clk, .i_srst,
    .i_req, .i_cfg, .i_core, .o_accept, .o_mode, .o_clean_l1,
    .o_clean_l2, .o_coherent, .o_inval, .o_warm_rst, .o_pwr_on,
    .o_clk_en, .o_dbg_err, .o_dbg_live, .o_warm_req);
`default_nettype wire

// File: cpm_policy_model.sv
// cpm_policy_model: policy controller side of the mode handshake.
// assumes the bench pulses i_go for one cycle per request.
`timescale 1ns/1ps
`default_nettype none
module cpm_policy_model (
    input  wire logic               i_clk,
    input  wire logic               i_srst,
    input  wire logic               i_go,
    input  wire cpm_pkg::cpm_mode_t i_mode,
    input  wire logic               i_accept,
    output var  cpm_pkg::cpm_req_t  o_req,
    output var  int                 o_lat
);
    // gives up after 40 cycles so a refused code cannot hang the run
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_req <= '0;
            o_lat <= 0;
        end else if (i_go) begin
            o_req <= {1'b1, i_mode};
            o_lat <= 0;
        end else if (o_req.req && (i_accept || o_lat == 40)) begin
            o_req <= {1'b0, ~o_req.mode};
        end else if (o_req.req) begin
            o_lat <= o_lat + 1;
        end
    end
endmodule
`default_nettype wire

// File: cpm_core_power_tb.sv
// cpm_core_power_tb: mode sweep, refusal and reset-event tests.
// assumes the policy model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cpm_core_power_tb;
    import cpm_pkg::*;
    logic        i_clk = 0;
    logic        i_srst = 1;
    logic        go = 0;
    cpm_mode_t   gm = CPM_ON;
    cpm_mode_t   mo;
    cpm_req_t    rq;
    cpm_cfg_t    cfg = {1'b1, 8'h02, 1'b0};
    cpm_core_t   core = '0;
    logic        acc, vo, coh, inv, wr, pw, ce, de, dl, wq;
    int          lat, n_inv = 0, failures = 0, n_checks = 0;
    logic [31:0] rs = 32'hb65caa08;
    cpm_mode_t   seq[$] = '{CPM_FUNCTIONAL_RETENTION, CPM_ON, CPM_DEBUG_RECOVERY, CPM_ON,
        CPM_WARM_RST, CPM_ON, CPM_EMU_OFF, CPM_ON, CPM_OFF, CPM_ON,
        CPM_FULL_RETENTION};
    cpm_core_power uut (.i_clk(i_clk), .i_srst(i_srst), .i_req(rq),
        .i_cfg(cfg), .i_core(core), .o_accept(acc), .o_mode(mo),
        .o_vec_off(vo), .o_vec_ret_req(), .o_clean_l1(), .o_clean_l2(),
        .o_coherent(coh), .o_inval(inv), .o_warm_rst(wr), .o_pwr_on(pw),
        .o_clk_en(ce), .o_dbg_err(de), .o_dbg_live(dl), .o_warm_req(wq));
    cpm_policy_model ppc (.i_clk(i_clk), .i_srst(i_srst), .i_go(go),
        .i_mode(gm), .i_accept(acc), .o_req(rq), .o_lat(lat));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (inv === 1'b1) n_inv++;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic bad(input logic [31:0] g, e);
        failures++;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
    endtask
    task automatic chk_b(input logic g, e);
        n_checks++;
        if (g !== e) bad({31'h0, g}, {31'h0, e});
    endtask
    task automatic chk_n(input int g, e);
        n_checks++;
        if (g != e) bad(g, e);
    endtask
    task automatic chk_m(input cpm_mode_t g, e);
        n_checks++;
        if (g !== e) bad({29'h0, g}, {29'h0, e});
    endtask
    // el < 0: accept time depends on the retention timer
    task automatic do_req(input cpm_mode_t m,
                          input int        el,
                          input cpm_mode_t em);
        int k;
        k = 0;
        @(posedge i_clk);
        go <= 1;
        gm <= m;
        @(posedge i_clk);
        go <= 0;
        @(posedge i_clk);
        while (rq.req && k < 100) begin
            @(posedge i_clk);
            k++;
        end
        #1;
        if (el < 0) chk_b(lat < 40, 1'b1);
        else chk_n(lat, el);
        chk_m(mo, em);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 0;
        @(posedge i_clk);
        #1;
        chk_m(mo, CPM_ON);
        chk_b(coh & pw & ce & dl, 1'b1);
        chk_b(acc | inv | wr | de | wq, 1'b0);
        $display("test reset done");
        foreach (seq[i]) begin
            @(posedge i_clk);
            core.in_wait <= (seq[i] == CPM_FULL_RETENTION);
            // idle vector unit so the retention timer can run out
            core.vec_idle <= 1'b1;
            core.vec_pending <= 1'b0;
            do_req(seq[i], seq[i] == CPM_FULL_RETENTION ? -1 :
                (seq[i] inside {CPM_OFF, CPM_EMU_OFF}) ? 7 : 2, seq[i]);
            if (seq[i] == CPM_FUNCTIONAL_RETENTION) begin
                repeat (40) begin
                    @(posedge i_clk);
                    rs = xs(rs);
                    core.vec_idle <= rs[0];
                    core.vec_pending <= rs[1] & rs[2];
                    core.peer_vec_req <= rs[3] | rs[4];
                    cfg.ret_en <= rs[5] | rs[6];
                    core.peer_off <= rs[7];
                end
                core.vec_pending <= 1;
                repeat (2) @(posedge i_clk);
                #1;
                chk_b(vo, 1'b0);
            end
            if (seq[i] == CPM_OFF) begin
                @(posedge i_clk);
                core.dbg_acc <= 1;
                @(posedge i_clk);
                core.dbg_acc <= 0;
                #1;
                chk_b(de, 1'b1);
            end
        end
        @(posedge i_clk);
        core.wake_evt <= 1;
        core.in_wait <= 0;
        @(posedge i_clk);
        core.wake_evt <= 0;
        @(posedge i_clk);
        #1;
        chk_m(mo, CPM_ON);
        chk_n(n_inv, 1);
        $display("test mode sweep done");
        do_req(cpm_mode_t'(3'h7), 40, CPM_ON);
        $display("test refusal done");
        @(posedge i_clk);
        cfg.rst_req_bit <= 1;
        core.wfi_exec <= 1;
        @(posedge i_clk);
        core.wfi_exec <= 0;
        core.bridge_warm <= 1;
        #1;
        chk_b(wq, 1'b1);
        @(posedge i_clk);
        core.bridge_warm <= 0;
        #1;
        chk_b(wr, 1'b1);
        $display("test warm reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
